// *** design/autoreclose_initiate_lockout_ctrl.sv ***
// autoreclose initiation, lockout, last-shot, skip and stall control
// ==========================================
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "arc_defs.svh"
module autoreclose_initiate_lockout_ctrl #(
  parameter int TICK_CYCLES = `ARC_TICK_CYCLES,
  parameter int DROP_CYCLES = `ARC_DROPOUT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ARC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reclose_initiate,
  input wire logic reclose_initiate_supervision,
  input wire logic drive_to_lockout,
  input wire logic drive_to_last_shot,
  input wire logic skip_shot,
  input wire logic stall_open_interval,
  input wire logic breaker_closed_status,
  input wire logic sequence_reset,
  output logic lockout_state_flag,
  output logic lockout_indicator,
  output logic reclose_cycle_flag,
  output logic open_interval_timing_flag,
  output logic [4:0] shot_flags,
  output logic shot_zero_flag,
  output logic close_request
);
  // ==========================================
  // synchronised pins
  logic [6:0] pin_lvl;
  logic dtl_held;
  logic ri, ris, dls, skp, stl, brk, dtl_raw;

  pin_sync #(.W(7)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin({breaker_closed_status, stall_open_interval, skip_shot,
          drive_to_last_shot, drive_to_lockout,
          reclose_initiate_supervision, reclose_initiate}),
    .level(pin_lvl)
  );

  assign ri = pin_lvl[0];
  assign ris = pin_lvl[1];
  assign dtl_raw = pin_lvl[2];
  assign dls = pin_lvl[3];
  assign skp = pin_lvl[4];
  assign stl = pin_lvl[5];
  assign brk = pin_lvl[6];

  dropout_stretch #(.DROP_CYCLES(DROP_CYCLES)) u_dtl (
    .pclk(pclk),
    .presetn(presetn),
    .level(dtl_raw),
    .held(dtl_held)
  );

  // ==========================================
  // state
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [3:0][15:0] oi;
    arc_pkg::seq_state_e state;
    logic [2:0] shot;
    logic [2:0] last;
    logic pending;
    logic started;
    logic [15:0] timer;
    logic [15:0] presc;
    logic ri_prev;
    logic skp_prev;
    logic close;
    logic lockout;
    logic cycle;
    logic timing;
    logic [4:0] shot_oh;
  } ctrl_s;
  ctrl_s q, d;

  logic acc, take, hit, rise, skr, tick, arm, seq_rst;
  logic [2:0] lastc, nshot;
  logic [31:0] rd;

  always_comb begin
    d = q;
    d.close = 1'b0;
    arm = 1'b0;
    nshot = q.shot;
    // ==========================================
    // apb slave, one wait state
    acc = psel & penable;
    take = acc & q.pready;
    hit = 1'b1;
    rd = 32'h0;
    unique case (paddr)
      `ARC_OI1_OFS, `ARC_OI2_OFS, `ARC_OI3_OFS, `ARC_OI4_OFS: begin
        rd = {16'h0, q.oi[paddr[3:2]]};
      end
      `ARC_STATUS_OFS: begin
        rd[`ARC_ST_SHOT_LSB +: 3] = q.shot;
        rd[`ARC_ST_LAST_LSB +: 3] = q.last;
        rd[`ARC_ST_LOCKOUT_BIT] = q.lockout;
        rd[`ARC_ST_CYCLE_BIT] = q.cycle;
        rd[`ARC_ST_TIMING_BIT] = q.timing;
        rd[`ARC_ST_DTL_BIT] = dtl_held;
        rd[`ARC_ST_PENDING_BIT] = q.pending;
      end
      `ARC_CMD_OFS: rd = 32'h0;
      default: hit = 1'b0;
    endcase
    d.pready = acc & ~q.pready;
    d.pslverr = acc & ~q.pready & ~hit;
    if (acc & ~q.pready) begin
      d.prdata = pwrite ? 32'h0 : rd;
    end
    if (take & pwrite & hit & (paddr[7:4] == 4'h0)) begin
      d.oi[paddr[3:2]] = pwdata[15:0];
    end
    seq_rst = sequence_reset |
      (take & pwrite & (paddr == `ARC_CMD_OFS) &
       pwdata[`ARC_CMD_RESET_BIT]);
    // ==========================================
    // last shot from configured intervals
    lastc = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if (q.oi[i] != 16'h0) begin
        lastc = lastc + 3'h1;
      end
    end
    d.last = (lastc > `ARC_MAX_SHOT) ? `ARC_MAX_SHOT : lastc;
    // ==========================================
    // edges and millisecond tick
    rise = ri & ~q.ri_prev;
    skr = skp & ~q.skp_prev;
    d.ri_prev = ri;
    d.skp_prev = skp;
    tick = (q.presc == 16'h0);
    d.presc = tick ? 16'(TICK_CYCLES - 1) : q.presc - 16'h1;
    // ==========================================
    // sequencing
    if (seq_rst) begin
      d.state = arc_pkg::st_reset;
      d.shot = 3'h0;
      d.pending = 1'b0;
      d.started = 1'b0;
    end else begin
      if (q.started && !stl && tick) begin
        if (q.timer <= 16'h1) begin
          d.shot = q.shot + 3'h1;
          d.close = 1'b1;
          d.pending = 1'b0;
          d.started = 1'b0;
          d.timer = 16'h0;
        end else begin
          d.timer = q.timer - 16'h1;
        end
      end
      if (q.state != arc_pkg::st_lockout && rise) begin
        if (!ris || q.shot >= q.last) begin
          d.state = arc_pkg::st_lockout;
        end else begin
          d.state = arc_pkg::st_cycle;
          d.pending = 1'b1;
          d.started = 1'b0;
          arm = 1'b1;
        end
      end else if (q.pending && !q.started && skr) begin
        arm = 1'b1;
      end
      if (arm) begin
        nshot = skp ? q.shot + 3'h1 : q.shot;
        d.shot = nshot;
        if (skp && nshot >= q.last) begin
          d.pending = 1'b0;
          if (!brk) begin
            d.state = arc_pkg::st_lockout;
          end
        end else begin
          d.timer = q.oi[nshot[1:0]];
        end
      end
      if (d.pending && !d.started && !stl) begin
        d.started = 1'b1;
      end
      if (dls && d.shot < q.last) begin
        d.shot = q.last;
      end
      if (dtl_held) begin
        d.state = arc_pkg::st_lockout;
      end
      if (d.state == arc_pkg::st_lockout) begin
        d.pending = 1'b0;
        d.started = 1'b0;
      end
    end
    // ==========================================
    // status outputs
    d.lockout = (d.state == arc_pkg::st_lockout);
    d.cycle = (d.state == arc_pkg::st_cycle);
    d.timing = d.started & ~stl & d.cycle;
    for (int i = 0; i < 5; i++) begin
      d.shot_oh[i] = (d.shot == 3'(i));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.shot_oh <= 5'h01;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign lockout_state_flag = q.lockout;
  assign lockout_indicator = q.lockout;
  assign reclose_cycle_flag = q.cycle;
  assign open_interval_timing_flag = q.timing;
  assign shot_flags = q.shot_oh;
  assign shot_zero_flag = q.shot_oh[0];
  assign close_request = q.close;

  // ==========================================
  // checks
  shot_onehot_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $onehot(shot_flags) && shot_flags[q.shot])
    else $error("shot flags not one-hot");

  timing_state_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    open_interval_timing_flag |-> reclose_cycle_flag && q.started)
    else $error("timing flag outside interval");

  unsup_lock_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rise && !ris && !seq_rst) |=> lockout_state_flag)
    else $error("unsupervised initiate did not lock out");

  no_initiate_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (q.state == arc_pkg::st_reset && !rise) |=> !reclose_cycle_flag)
    else $error("cycle began without initiate");

  dtl_lock_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (dtl_held && !seq_rst) |=> lockout_state_flag && lockout_indicator)
    else $error("drive-to-lockout ignored");

  dls_shot_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (dls && !seq_rst && q.shot < q.last) |=> q.shot >= $past(q.last))
    else $error("not driven to last shot");

  stall_freeze_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (q.started && stl && !rise && !seq_rst) |=> $stable(q.timer))
    else $error("timer moved while stalled");

  stall_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (q.pending && !q.started && stl) |=> !open_interval_timing_flag)
    else $error("timer started under stall");

  fail_lock_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rise && q.shot >= q.last && !seq_rst) |=> lockout_state_flag)
    else $error("failed sequence not locked out");

  last_shot_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    q.last <= `ARC_MAX_SHOT)
    else $error("last shot above four");

  skip_bump_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (arm && skp && !dls) |=> q.shot == $past(q.shot) + 3'h1)
    else $error("skip did not advance the shot");

  skip_lock_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (arm && skp && nshot >= q.last && !brk) |=> lockout_state_flag)
    else $error("skip to last shot did not lock out");

  stall_skip_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (q.pending && !q.started && skr && !rise && !dls && !seq_rst)
    |=> q.shot == $past(q.shot) + 3'h1)
    else $error("skip ignored while stalled");
endmodule
`default_nettype wire

// *** design/arc_defs.svh ***
// register map, field positions and timing counts of the autoreclose control
`ifndef ARC_DEFS_SVH
`define ARC_DEFS_SVH
`define ARC_PCLK_PERIOD_NS 40
`define ARC_TICK_NS 1000000
`define ARC_TICK_CYCLES (`ARC_TICK_NS / `ARC_PCLK_PERIOD_NS)
`define ARC_DROPOUT_NS 1000000000
`define ARC_DROPOUT_CYCLES (`ARC_DROPOUT_NS / `ARC_PCLK_PERIOD_NS)
`define ARC_MAX_SHOT 3'h4
`define ARC_ADDR_W 8
`define ARC_OI1_OFS 8'h00
`define ARC_OI2_OFS 8'h04
`define ARC_OI3_OFS 8'h08
`define ARC_OI4_OFS 8'h0c
`define ARC_STATUS_OFS 8'h10
`define ARC_CMD_OFS 8'h14
`define ARC_OI_RST 16'h0000
`define ARC_ST_SHOT_LSB 0
`define ARC_ST_LAST_LSB 4
`define ARC_ST_LOCKOUT_BIT 8
`define ARC_ST_CYCLE_BIT 9
`define ARC_ST_TIMING_BIT 10
`define ARC_ST_DTL_BIT 11
`define ARC_ST_PENDING_BIT 12
`define ARC_CMD_RESET_BIT 0
`endif

// *** design/arc_pkg.sv ***
// types shared by the autoreclose control
package arc_pkg;
  typedef enum logic [1:0] {
    st_reset,
    st_cycle,
    st_lockout
  } seq_state_e;
endpackage

// *** design/pin_sync.sv ***
// three-stage pin synchroniser with agreement of the last two stages
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 7
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  // ==========================================
  // state
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] o;
  } sync_s;
  sync_s q, d;

  always_comb begin
    d = q;
    d.s1 = pin;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.o = (q.s2 & q.s3) | (q.o & (q.s2 ^ q.s3));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level = q.o;
endmodule
`default_nettype wire

// *** design/dropout_stretch.sv ***
// holds a level high for a fixed dropout time after it falls
`timescale 1ns/1ps
`default_nettype none
`include "arc_defs.svh"
module dropout_stretch #(
  parameter int DROP_CYCLES = `ARC_DROPOUT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic level,
  output logic held
);
  // ==========================================
  // state
  typedef struct packed {
    logic [31:0] cnt;
    logic hold;
  } drop_s;
  drop_s q, d;

  always_comb begin
    d = q;
    if (level) begin
      d.cnt = 32'(DROP_CYCLES);
    end else if (q.cnt != 32'h0) begin
      d.cnt = q.cnt - 32'h1;
    end
    d.hold = level | (d.cnt != 32'h0);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign held = q.hold;

  // ==========================================
  // checks
  hold_after_fall_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!level && q.cnt > 32'h1) |=> held)
    else $error("dropout released early");
endmodule
`default_nettype wire

// *** bench/breaker_trip_model.sv ***
// breaker and trip model standing at the pin side of the autoreclose control
`timescale 1ns/1ps
`default_nettype none
module breaker_trip_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic trip,
  input wire logic close_request,
  output logic reclose_initiate,
  output logic breaker_closed_status
);
  // ==========================================
  // trip opens the breaker, a close pulse closes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reclose_initiate <= 1'b0;
      breaker_closed_status <= 1'b1;
    end else begin
      reclose_initiate <= trip;
      if (trip) begin
        breaker_closed_status <= 1'b0;
      end else if (close_request) begin
        breaker_closed_status <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
// self-checking bench for the autoreclose initiation and lockout control
`timescale 1ns/1ps
`default_nettype none
`include "arc_defs.svh"
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, e, reclose_initiate, breaker_closed_status;
  logic reclose_initiate_supervision = 1'b1;
  logic drive_to_lockout = 1'b0;
  logic drive_to_last_shot = 1'b0;
  logic skip_shot = 1'b0;
  logic stall_open_interval = 1'b0;
  logic sequence_reset = 1'b0;
  logic trip = 1'b0;
  logic lockout_state_flag, lockout_indicator, reclose_cycle_flag;
  logic open_interval_timing_flag, shot_zero_flag, close_request;
  logic [4:0] shot_flags;
  int fail_count = 0;
  int num_checks = 0;
  int seed = 92;
  int m_shot, m_last, n;
  // ==========================================
  // clock, design and partner
  always #20 pclk = ~pclk;
  autoreclose_initiate_lockout_ctrl #(.TICK_CYCLES(4), .DROP_CYCLES(20)) uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .reclose_initiate, .reclose_initiate_supervision,
    .drive_to_lockout, .drive_to_last_shot, .skip_shot,
    .stall_open_interval, .breaker_closed_status, .sequence_reset,
    .lockout_state_flag, .lockout_indicator, .reclose_cycle_flag,
    .open_interval_timing_flag, .shot_flags, .shot_zero_flag, .close_request
  );
  breaker_trip_model bkr (.pclk, .presetn, .trip, .close_request,
    .reclose_initiate, .breaker_closed_status);
  // ==========================================
  // tasks
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tk(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      wrap_up();
    end
  endtask
  task automatic st;
    apb(1'b0, `ARC_STATUS_OFS, 32'h0);
    chk(32'(q[2:0]), 32'(m_shot));
    chk(32'(q[6:4]), 32'(m_last));
    chk(32'(shot_flags), 32'h1 << m_shot);
  endtask
  task automatic fl(input logic [2:0] x);
    chk(32'({lockout_state_flag, reclose_cycle_flag,
      open_interval_timing_flag}), 32'(x));
    chk(32'(lockout_indicator), 32'(x[2]));
  endtask
  task automatic rs;
    sequence_reset <= 1'b1;
    tk(1);
    sequence_reset <= 1'b0;
    tk(2);
    m_shot = 0;
  endtask
  task automatic wait_close;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (close_request !== 1'b1 && n < 200);
    chk(32'(n < 200), 32'h1);
    if (n >= 200) begin
      wrap_up();
    end
  endtask
  // ==========================================
  // main sequence
  initial begin
    tk(8);
    presetn <= 1'b1;
    tk(2);
    chk(32'(shot_flags), 32'h01);
    chk(32'(shot_zero_flag), 32'h1);
    m_shot = 0;
    m_last = 2;
    apb(1'b1, `ARC_OI1_OFS, 32'(2 + ($random(seed) & 1)));
    apb(1'b1, `ARC_OI2_OFS, 32'(2 + ($random(seed) & 3)));
    st();
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, e}, 32'h1);
    fl(3'b000);
    $display("end of test 1");
    repeat (2) begin
      trip <= 1'b1;
      tk(7);
      fl(3'b011);
      trip <= 1'b0;
      wait_close();
      m_shot++;
      tk(6);
      fl(3'b010);
      st();
    end
    trip <= 1'b1;
    tk(7);
    fl(3'b100);
    st();
    trip <= 1'b0;
    apb(1'b1, `ARC_CMD_OFS, 32'h1);
    m_shot = 0;
    tk(2);
    fl(3'b000);
    $display("end of test 2");
    reclose_initiate_supervision <= 1'b0;
    trip <= 1'b1;
    tk(7);
    fl(3'b100);
    trip <= 1'b0;
    reclose_initiate_supervision <= 1'b1;
    rs();
    fl(3'b000);
    $display("end of test 3");
    drive_to_lockout <= 1'b1;
    tk(3);
    drive_to_lockout <= 1'b0;
    tk(6);
    fl(3'b100);
    rs();
    tk(1);
    fl(3'b100);
    tk(30);
    rs();
    fl(3'b000);
    $display("end of test 4");
    drive_to_last_shot <= 1'b1;
    tk(6);
    m_shot = m_last;
    st();
    drive_to_last_shot <= 1'b0;
    tk(6);
    rs();
    $display("end of test 5");
    stall_open_interval <= 1'b1;
    skip_shot <= 1'b1;
    trip <= 1'b1;
    tk(6);
    m_shot = 1;
    st();
    fl(3'b010);
    skip_shot <= 1'b0;
    tk(6);
    skip_shot <= 1'b1;
    tk(6);
    m_shot = 2;
    fl(3'b100);
    st();
    trip <= 1'b0;
    skip_shot <= 1'b0;
    stall_open_interval <= 1'b0;
    rs();
    $display("end of test 6");
    apb(1'b1, `ARC_OI1_OFS, 32'h8);
    trip <= 1'b1;
    tk(7);
    fl(3'b011);
    stall_open_interval <= 1'b1;
    tk(6);
    fl(3'b010);
    tk(40);
    st();
    trip <= 1'b0;
    stall_open_interval <= 1'b0;
    wait_close();
    m_shot = 1;
    st();
    $display("end of test 7");
    wrap_up();
  end
endmodule
`default_nettype wire
